// ### hw/mrc_pkg.sv
// Shared types and constants of the register value codec
package mrc_pkg;

    // ------------------------------------------------------------------
    // Value kinds
    // ------------------------------------------------------------------
    typedef enum logic [3:0] {
        MRC_BOOL = 4'h0,
        MRC_U16  = 4'h1,
        MRC_I16  = 4'h2,
        MRC_U32  = 4'h3,
        MRC_I32  = 4'h4,
        MRC_U64  = 4'h5,
        MRC_DATE = 4'h6,
        MRC_TEXT = 4'h7,
        MRC_REAL = 4'h8
    } mrc_type_t;

    // ------------------------------------------------------------------
    // Encodings and field positions
    // ------------------------------------------------------------------
    localparam logic [15:0] MRC_BOOL_TRUE   = 16'hFFFF;
    localparam logic [15:0] MRC_BOOL_FALSE  = 16'h0000;
    localparam logic [15:0] MRC_ZERO16      = 16'h0000;
    localparam logic [7:0]  MRC_EXC_NAN     = 8'h04;
    localparam logic [7:0]  MRC_EXC_ILLEGAL = 8'h03;
    localparam logic [7:0]  MRC_EXC_NONE    = 8'h00;
    localparam logic [7:0]  MRC_EXP_ONES    = 8'hFF;
    localparam int          MRC_EXP_HI      = 30;
    localparam int          MRC_EXP_LO      = 23;
    localparam logic [31:0] MRC_YEAR_MUL    = 32'h0000_2710;
    localparam logic [31:0] MRC_MONTH_MUL   = 32'h0000_0064;
    localparam logic [4:0]  MRC_TXT_WORDS   = 5'h10;

    // ------------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------------
    typedef struct packed {
        mrc_type_t   kind;
        logic [63:0] val;
    } mrc_val_t;

    typedef struct packed {
        logic [15:0] word;
        logic        last;
    } mrc_rd_word_t;

    // Register count of each kind
    function automatic logic [4:0] mrc_words(input mrc_type_t t);
        logic [4:0] n;
        n = 5'h01;
        case (t)
            MRC_U32, MRC_I32, MRC_REAL: n = 5'h02;
            MRC_U64, MRC_DATE:          n = 5'h04;
            MRC_TEXT:                   n = MRC_TXT_WORDS;
            default:                    n = 5'h01;
        endcase
        return n;
    endfunction : mrc_words

endpackage : mrc_pkg

// ### hw/mrc_txt_mem.sv
// Sixteen-word store for the text field, registered read
`timescale 1ns/1ns
module mrc_txt_mem (
    input  wire logic        i_clk,   // System clock
    input  wire logic        i_rst_b, // Async reset, active low
    input  wire logic        i_we,    // Write strobe
    input  wire logic [3:0]  i_waddr, // Write word index
    input  wire logic [15:0] i_wdata, // Write word
    input  wire logic [3:0]  i_raddr, // Read word index
    output logic      [15:0] o_rdata  // Read word, one cycle later
);
    logic [15:0] mem_q [16];
    logic [15:0] rdata_d;

    // Read data selection
    always_comb begin
        rdata_d = mem_q[i_raddr];
    end

    // Array write, no reset on storage
    always_ff @(posedge i_clk) begin
        if (i_we) begin
            mem_q[i_waddr] <= i_wdata;
        end
    end

    // Read register
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_rdata <= 16'h0000;
        end else begin
            o_rdata <= rdata_d;
        end
    end
endmodule : mrc_txt_mem

// ### hw/mrc_codec.sv
// Register value codec: core values to register words and back
`timescale 1ns/1ns
// Operation
// - Boolean register is 0x0000 false, 0xFFFF true, else invalid
// - Unsigned 16-bit value fills exactly one register, full range
// - Signed 16-bit value in one register, top bit is sign
// - 32-bit values span two registers joined into one word; bit 31 sign for signed and real, not unsigned
// - 64-bit value spans four registers, split on read, joined on write
// - Date stamp upper half is year*10000 + month*100 + day
// - Date stamp lower thirty-two bits are zero
// - Text field is sixteen registers, two characters each, moved whole
// - Characters packed in pairs, first pair in first register
// - Earlier character in bits 7:0, later in bits 15:8
// - Real value is binary32: sign, biased exponent, fraction
// - Never return a NaN real; answer exception code 4 instead
// - Real value: first register upper half, second lower half
// - Multi-register values go most significant part first
module mrc_codec (
    input  wire logic                  i_clk,        // System clock
    input  wire logic                  i_rst_b,      // Async reset, active low
    input  wire logic                  i_rd_req,     // Read request pulse
    input  wire mrc_pkg::mrc_type_t    i_rd_kind,    // Kind to read
    input  wire logic [63:0]           i_core_val,   // Core value, right aligned
    input  wire logic [13:0]           i_date_year,  // Date year
    input  wire logic [3:0]            i_date_month, // Date month
    input  wire logic [4:0]            i_date_day,   // Date day
    output logic                       o_rd_busy,    // Read in progress
    output logic                       o_rd_valid,   // Read word strobe
    output mrc_pkg::mrc_rd_word_t      o_rd_word,    // Read word and last flag
    output logic                       o_rd_exc,     // Read exception pulse
    output logic [7:0]                 o_rd_exc_code,// Read exception code
    input  wire logic                  i_wr_valid,   // Write word strobe
    input  wire mrc_pkg::mrc_type_t    i_wr_kind,    // Kind being written
    input  wire logic [15:0]           i_wr_word,    // Write word
    output logic                       o_wr_done,    // Decoded value pulse
    output mrc_pkg::mrc_val_t          o_wr_res,     // Decoded value
    output logic                       o_wr_exc,     // Write exception pulse
    output logic [7:0]                 o_wr_exc_code,// Write exception code
    input  wire logic                  i_chr_rd,     // Character read pulse
    input  wire logic [4:0]            i_chr_idx,    // Character index 0..31
    output logic                       o_chr_valid,  // Character strobe
    output logic [7:0]                 o_chr         // Character byte
);
    import mrc_pkg::*;

    // ------------------------------------------------------------------
    // Read side state
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        MRC_ST_IDLE = 2'b00,
        MRC_ST_SEND = 2'b01,
        MRC_ST_TEXT = 2'b10
    } mrc_state_t;

    mrc_state_t   state_q, state_d;
    logic [63:0]  sh_q, sh_d;
    logic [4:0]   left_q, left_d;
    logic [3:0]   addr_q, addr_d;
    logic         pend_q, pend_d;
    logic         rvalid_d, rexc_d;
    mrc_rd_word_t rword_d;
    logic [7:0]   rexc_code_d;
    logic [31:0]  date_w;
    logic [3:0]   mem_raddr;
    logic [15:0]  mem_rdata;
    logic         chr_pend_q, chr_pend_d, chr_hi_q, chr_hi_d;
    logic         chr_valid_d;
    logic [7:0]   chr_d;

    // Packed decimal date, upper half of the stamp
    // decimal date pack
    assign date_w = 32'(i_date_year) * MRC_YEAR_MUL + 32'(i_date_month) * MRC_MONTH_MUL
                  + 32'(i_date_day);

    // Text store read port: serializer has priority over the core
    assign mem_raddr = (state_q == MRC_ST_TEXT) ? addr_q : i_chr_idx[4:1];

    // Read path next state
    always_comb begin
        state_d     = state_q;
        sh_d        = sh_q;
        left_d      = left_q;
        addr_d      = addr_q;
        pend_d      = 1'b0;
        rvalid_d    = 1'b0;
        rword_d     = '{word: MRC_ZERO16, last: 1'b0};
        rexc_d      = 1'b0;
        rexc_code_d = o_rd_exc_code;
        unique case (state_q)
            MRC_ST_IDLE: begin
                if (i_rd_req) begin
                    // Snapshot at request so all parts of a non-text value share one instant
                    left_d = mrc_words(i_rd_kind);
                    state_d = MRC_ST_SEND;
                    unique case (i_rd_kind)
                        MRC_BOOL: sh_d = {(i_core_val[0] ? MRC_BOOL_TRUE : MRC_BOOL_FALSE),
                                          48'h0};
                        MRC_U16, MRC_I16: sh_d = {i_core_val[15:0], 48'h0};
                        MRC_U32, MRC_I32, MRC_REAL: sh_d = {i_core_val[31:0], 32'h0};
                        MRC_DATE: sh_d = {date_w, 32'h0};
                        MRC_U64: sh_d = i_core_val;
                        MRC_TEXT: begin
                            state_d = MRC_ST_TEXT;
                            addr_d  = 4'h0;
                        end
                        default: state_d = MRC_ST_IDLE;
                    endcase
                    if (i_rd_kind == MRC_REAL &&
                        i_core_val[MRC_EXP_HI:MRC_EXP_LO] == MRC_EXP_ONES) begin
                        state_d     = MRC_ST_IDLE;
                        rexc_d      = 1'b1;
                        rexc_code_d = MRC_EXC_NAN;
                    end
                end
            end
            MRC_ST_SEND: begin
                rvalid_d = 1'b1;
                rword_d  = '{word: sh_q[63:48], last: (left_q == 5'h01)};
                sh_d     = {sh_q[47:0], 16'h0};
                left_d   = left_q - 5'h01;
                if (left_q == 5'h01) begin
                    state_d = MRC_ST_IDLE;
                end
            end
            MRC_ST_TEXT: begin
                if (left_q != 5'h00) begin
                    pend_d = 1'b1;
                    addr_d = addr_q + 4'h1;
                    left_d = left_q - 5'h01;
                end
                if (pend_q) begin
                    rvalid_d = 1'b1;
                    rword_d  = '{word: mem_rdata, last: (left_q == 5'h00)};
                    if (left_q == 5'h00) begin
                        state_d = MRC_ST_IDLE;
                    end
                end
            end
            default: state_d = MRC_ST_IDLE;
        endcase
    end

    // Core character read next values
    always_comb begin
        chr_pend_d  = i_chr_rd && (state_q != MRC_ST_TEXT);
        chr_hi_d    = i_chr_idx[0];
        chr_valid_d = chr_pend_q;
        chr_d       = chr_hi_q ? mem_rdata[15:8] : mem_rdata[7:0];
        if (!chr_pend_q) begin
            chr_d = o_chr;
        end
    end

    // Read side registers
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            state_q       <= MRC_ST_IDLE;
            sh_q          <= 64'h0;
            left_q        <= 5'h00;
            addr_q        <= 4'h0;
            pend_q        <= 1'b0;
            o_rd_busy     <= 1'b0;
            o_rd_valid    <= 1'b0;
            o_rd_word     <= '0;
            o_rd_exc      <= 1'b0;
            o_rd_exc_code <= MRC_EXC_NONE;
            chr_pend_q    <= 1'b0;
            chr_hi_q      <= 1'b0;
            o_chr_valid   <= 1'b0;
            o_chr         <= 8'h00;
        end else begin
            state_q       <= state_d;
            sh_q          <= sh_d;
            left_q        <= left_d;
            addr_q        <= addr_d;
            pend_q        <= pend_d;
            o_rd_busy     <= (state_d != MRC_ST_IDLE);
            o_rd_valid    <= rvalid_d;
            o_rd_word     <= rword_d;
            o_rd_exc      <= rexc_d;
            o_rd_exc_code <= rexc_code_d;
            chr_pend_q    <= chr_pend_d;
            chr_hi_q      <= chr_hi_d;
            o_chr_valid   <= chr_valid_d;
            o_chr         <= chr_d;
        end
    end

    // ------------------------------------------------------------------
    // Write side: assemble register words into values
    // ------------------------------------------------------------------
    logic [4:0]  wcnt_q, wcnt_d;
    logic [63:0] acc_q, acc_d;
    logic        wdone_d, wexc_d, mem_we;
    mrc_val_t    wres_d;
    logic [7:0]  wexc_code_d;

    // Write path next values
    always_comb begin
        wcnt_d      = wcnt_q;
        acc_d       = acc_q;
        wdone_d     = 1'b0;
        wexc_d      = 1'b0;
        wexc_code_d = o_wr_exc_code;
        wres_d      = o_wr_res;
        mem_we      = 1'b0;
        if (i_wr_valid) begin
            acc_d  = {acc_q[47:0], i_wr_word};
            mem_we = (i_wr_kind == MRC_TEXT);
            wcnt_d = wcnt_q + 5'h01;
            if (i_wr_kind == MRC_BOOL && i_wr_word != MRC_BOOL_TRUE &&
                i_wr_word != MRC_BOOL_FALSE) begin
                wexc_d      = 1'b1;
                wexc_code_d = MRC_EXC_ILLEGAL;
                wcnt_d      = 5'h00;
            end else if (wcnt_d == mrc_words(i_wr_kind)) begin
                wdone_d     = 1'b1;
                wcnt_d      = 5'h00;
                wres_d.kind = i_wr_kind;
                unique case (i_wr_kind)
                    MRC_BOOL: wres_d.val = {63'h0, (i_wr_word == MRC_BOOL_TRUE)};
                    MRC_U16:  wres_d.val = {48'h0, i_wr_word};
                    MRC_I16:  wres_d.val = {{48{i_wr_word[15]}}, i_wr_word};
                    MRC_U32, MRC_REAL: wres_d.val = {32'h0, acc_d[31:0]};
                    MRC_I32:  wres_d.val = {{32{acc_d[31]}}, acc_d[31:0]};
                    MRC_U64, MRC_DATE: wres_d.val = acc_d;
                    default:  wres_d.val = 64'h0;
                endcase
            end
        end
    end

    // Write side registers
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            wcnt_q        <= 5'h00;
            acc_q         <= 64'h0;
            o_wr_done     <= 1'b0;
            o_wr_res      <= '{kind: MRC_BOOL, val: 64'h0};
            o_wr_exc      <= 1'b0;
            o_wr_exc_code <= MRC_EXC_NONE;
        end else begin
            wcnt_q        <= wcnt_d;
            acc_q         <= acc_d;
            o_wr_done     <= wdone_d;
            o_wr_res      <= wres_d;
            o_wr_exc      <= wexc_d;
            o_wr_exc_code <= wexc_code_d;
        end
    end

    // Text store; word index follows arrival order
    // field words stored in order
    mrc_txt_mem u_txt_mem (
        .i_clk   (i_clk),
        .i_rst_b (i_rst_b),
        .i_we    (mem_we),
        .i_waddr (wcnt_q[3:0]),
        .i_wdata (i_wr_word),
        .i_raddr (mem_raddr),
        .o_rdata (mem_rdata)
    );

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    logic        rd_go;
    logic [15:0] core_hi, core_lo;
    assign rd_go   = i_rd_req && (state_q == MRC_ST_IDLE);
    assign core_hi = i_core_val[31:16];
    assign core_lo = i_core_val[15:0];

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_b);

    AST_BOOL_RD: assert property (rd_go && i_rd_kind == MRC_BOOL |-> ##2
        (o_rd_valid && o_rd_word.last && (o_rd_word.word == MRC_BOOL_TRUE ||
         o_rd_word.word == MRC_BOOL_FALSE)))
        else $error("boolean read word malformed");
    AST_NAN_EXC: assert property (rd_go && i_rd_kind == MRC_REAL &&
        i_core_val[MRC_EXP_HI:MRC_EXP_LO] == MRC_EXP_ONES |=>
        (o_rd_exc && o_rd_exc_code == MRC_EXC_NAN) ##1 !o_rd_valid)
        else $error("NaN not refused with code 4");
    AST_REAL_ORDER: assert property (rd_go && i_rd_kind == MRC_REAL &&
        i_core_val[MRC_EXP_HI:MRC_EXP_LO] != MRC_EXP_ONES |-> ##2
        (o_rd_valid && o_rd_word.word == $past(core_hi, 2) && !o_rd_word.last) ##1
        (o_rd_valid && o_rd_word.word == $past(core_lo, 3) && o_rd_word.last))
        else $error("real halves out of order");
    AST_DATE_LOW: assert property (rd_go && i_rd_kind == MRC_DATE |-> ##4
        (o_rd_valid && o_rd_word.word == MRC_ZERO16) ##1
        (o_rd_valid && o_rd_word.word == MRC_ZERO16 && o_rd_word.last))
        else $error("date stamp low half not zero");
    AST_U16_ONE: assert property (rd_go && i_rd_kind == MRC_U16 |-> ##2
        (o_rd_valid && o_rd_word.last && o_rd_word.word == $past(core_lo, 2)))
        else $error("u16 not a single register");
    AST_TXT_LEN: assert property (rd_go && i_rd_kind == MRC_TEXT |-> ##3
        (o_rd_valid && !o_rd_word.last)[*8] ##1 (o_rd_valid && !o_rd_word.last)[*7] ##1
        (o_rd_valid && o_rd_word.last))
        else $error("text field not sixteen words");
    AST_BOOL_WR_BAD: assert property (i_wr_valid && i_wr_kind == MRC_BOOL &&
        i_wr_word != MRC_BOOL_TRUE && i_wr_word != MRC_BOOL_FALSE |=>
        (o_wr_exc && o_wr_exc_code == MRC_EXC_ILLEGAL && !o_wr_done))
        else $error("invalid boolean write accepted");
    AST_I16_SIGN: assert property (i_wr_valid && i_wr_kind == MRC_I16 &&
        wcnt_q == 5'h00 |=> (o_wr_done && o_wr_res.val[63:16] == {48{$past(i_wr_word[15])}}))
        else $error("i16 sign not extended");
    AST_U32_WR: assert property (i_wr_valid && i_wr_kind == MRC_U32 &&
        wcnt_q == 5'h00 ##1 (i_wr_valid && i_wr_kind == MRC_U32) |=>
        (o_wr_done && o_wr_res.val[31:16] == $past(i_wr_word, 2) &&
         o_wr_res.val[15:0] == $past(i_wr_word)))
        else $error("u32 words not joined MSW first");
endmodule : mrc_codec

// ### bench/mrc_client_model.sv
// Bus client model: sends register words to the codec and gathers read words
`timescale 1ns/1ns
module mrc_client_model (
    input  wire logic                  i_clk,      // System clock
    input  wire logic                  i_rd_valid, // Read word strobe
    input  wire mrc_pkg::mrc_rd_word_t i_rd_word,  // Read word and last flag
    input  wire logic                  i_rd_exc,   // Read refused
    output logic                       o_rd_req,   // Read request pulse
    output mrc_pkg::mrc_type_t         o_rd_kind,  // Kind to read
    output logic                       o_wr_valid, // Write word strobe
    output mrc_pkg::mrc_type_t         o_wr_kind,  // Kind being written
    output logic [15:0]                o_wr_word   // Write word
);
    import mrc_pkg::*;

    logic [15:0] tx [16];   // Words to send, first one sent first
    logic [15:0] rx [16];   // Words gathered by the last read
    int          rx_n;      // Count of words gathered
    logic        rx_exc;    // Last read was refused

    // Idle levels at time zero
    initial begin
        o_rd_req   = 1'b0;
        o_rd_kind  = MRC_BOOL;
        o_wr_valid = 1'b0;
        o_wr_kind  = MRC_BOOL;
        o_wr_word  = 16'h0000;
    end

    // Send n whole words of one kind, one per cycle; entered just after an edge
    // every word of the value, padding included
    task automatic send(input mrc_type_t k, input int n);
        for (int i = 0; i < n; i++) begin
            o_wr_valid = 1'b1;
            o_wr_kind  = k;
            o_wr_word  = tx[i];
            @(posedge i_clk);
            #1;
        end
        o_wr_valid = 1'b0;
        // Released bus shows no stale word
        o_wr_word  = ~tx[n-1];
    endtask : send

    // One request gathers all parts of a value, from the same instant for every kind but text
    // single request per value
    task automatic read_value(input mrc_type_t k);
        o_rd_req  = 1'b1;
        o_rd_kind = k;
        @(posedge i_clk);
        #1;
        o_rd_req = 1'b0;
        rx_n     = 0;
        rx_exc   = 1'b0;
        for (int c = 0; c < 24; c++) begin
            if (i_rd_exc === 1'b1) begin
                rx_exc = 1'b1;
                break;
            end
            if (i_rd_valid === 1'b1 && rx_n < 16) begin
                rx[rx_n] = i_rd_word.word;
                rx_n++;
                if (i_rd_word.last === 1'b1) break;
            end
            @(posedge i_clk);
            #1;
        end
    endtask : read_value
endmodule : mrc_client_model

// ### bench/test_modbus_register_value_codec.sv
// Self-checking bench for the register value codec
`timescale 1ns/1ns
module test_modbus_register_value_codec;
    import mrc_pkg::*;

    // ------------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------------
    logic          clk = 1'b0;
    logic          rst_b;
    logic          rd_req, rd_busy, rd_valid, rd_exc;
    logic          wr_valid, wr_done, wr_exc, chr_rd, chr_valid;
    mrc_type_t     rd_kind, wr_kind;
    mrc_rd_word_t  rd_word;
    mrc_val_t      wr_res;
    logic [63:0]   core_val;
    logic [13:0]   d_year;
    logic [3:0]    d_month;
    logic [4:0]    d_day;
    logic [7:0]    rd_exc_code, wr_exc_code, chr;
    logic [15:0]   wr_word;
    logic [4:0]    chr_idx;
    int            n_mismatch = 0;
    int            n_compared = 0;
    int            n_cyc = 0;

    always #4 clk = ~clk;

    mrc_codec u_dut (.i_clk(clk), .i_rst_b(rst_b), .i_rd_req(rd_req), .i_rd_kind(rd_kind),
        .i_core_val(core_val), .i_date_year(d_year), .i_date_month(d_month),
        .i_date_day(d_day), .o_rd_busy(rd_busy), .o_rd_valid(rd_valid), .o_rd_word(rd_word),
        .o_rd_exc(rd_exc), .o_rd_exc_code(rd_exc_code), .i_wr_valid(wr_valid),
        .i_wr_kind(wr_kind), .i_wr_word(wr_word), .o_wr_done(wr_done), .o_wr_res(wr_res),
        .o_wr_exc(wr_exc), .o_wr_exc_code(wr_exc_code), .i_chr_rd(chr_rd),
        .i_chr_idx(chr_idx), .o_chr_valid(chr_valid), .o_chr(chr));

    mrc_client_model u_cli (.i_clk(clk), .i_rd_valid(rd_valid), .i_rd_word(rd_word),
        .i_rd_exc(rd_exc), .o_rd_req(rd_req), .o_rd_kind(rd_kind), .o_wr_valid(wr_valid),
        .o_wr_kind(wr_kind), .o_wr_word(wr_word));

    // ------------------------------------------------------------------
    // Compare and closing tasks
    // ------------------------------------------------------------------
    task automatic chk_w(input logic [15:0] got, input logic [15:0] exp, input string what);
        n_compared++;
        if (got !== exp) begin
            n_mismatch++;
            $display("BAD t=%0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : chk_w

    task automatic chk_v(input logic [63:0] got, input logic [63:0] exp, input string what);
        n_compared++;
        if (got !== exp) begin
            n_mismatch++;
            $display("BAD t=%0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : chk_v

    task automatic chk_b(input logic [7:0] got, input logic [7:0] exp, input string what);
        n_compared++;
        if (got !== exp) begin
            n_mismatch++;
            $display("BAD t=%0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : chk_b

    task automatic close_out();
        $display("compared %0d mismatched %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : close_out

    // Cut a hang short
    always @(posedge clk) begin
        n_cyc++;
        if (n_cyc == 5000) begin
            n_mismatch++;
            close_out();
        end
    end

    // ------------------------------------------------------------------
    // Shared steps
    // ------------------------------------------------------------------
    task automatic rd_chk(input mrc_type_t k, input int n, input logic [63:0] cv,
                          input logic [63:0] ev);
        core_val = cv;
        u_cli.read_value(k);
        chk_b(8'(u_cli.rx_n), 8'(n), "word count");
        for (int i = 0; i < n; i++) begin
            chk_w(u_cli.rx[i], ev[(n-1-i)*16 +: 16], "read word");
        end
    endtask : rd_chk

    task automatic wait_wr();
        for (int c = 0; c < 8; c++) begin
            if (wr_done === 1'b1 || wr_exc === 1'b1) break;
            @(posedge clk);
            #1;
        end
    endtask : wait_wr

    task automatic wr_chk(input mrc_type_t k, input int n, input logic [63:0] v,
                          input logic [63:0] ev);
        for (int i = 0; i < n; i++) begin
            u_cli.tx[i] = v[(n-1-i)*16 +: 16];
        end
        u_cli.send(k, n);
        wait_wr();
        chk_b({7'h0, wr_done}, 8'h01, "value done");
        chk_b({4'h0, wr_res.kind}, {4'h0, k}, "value kind");
        chk_v(wr_res.val, ev, "value");
    endtask : wr_chk

    task automatic chr_chk(input logic [4:0] idx, input logic [7:0] ev);
        chr_rd  = 1'b1;
        chr_idx = idx;
        @(posedge clk);
        #1;
        chr_rd = 1'b0;
        @(posedge clk);
        #1;
        chk_b({7'h0, chr_valid}, 8'h01, "char strobe");
        chk_b(chr, ev, "char byte");
    endtask : chr_chk

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task automatic t_bool();
        rd_chk(MRC_BOOL, 1, 64'h1, 64'hFFFF);
        rd_chk(MRC_BOOL, 1, 64'h0, 64'h0000);
        wr_chk(MRC_BOOL, 1, 64'hFFFF, 64'h1);
        u_cli.tx[0] = 16'h1234;
        u_cli.send(MRC_BOOL, 1);
        wait_wr();
        chk_b({7'h0, wr_exc}, 8'h01, "refused");
        chk_b({7'h0, wr_done}, 8'h00, "no done");
        chk_b(wr_exc_code, 8'h03, "write code");
        chk_v(wr_res.val, 64'h1, "value kept");
        wr_chk(MRC_BOOL, 1, 64'h0000, 64'h0);
        $display("test bool finished");
    endtask : t_bool

    task automatic t_ints();
        rd_chk(MRC_U16, 1, 64'hFFFF, 64'hFFFF);
        rd_chk(MRC_I16, 1, 64'h8001, 64'h8001);
        rd_chk(MRC_U32, 2, 64'h1234_5678, 64'h1234_5678);
        rd_chk(MRC_I32, 2, 64'hFFFF_FFFF_8000_0001, 64'h8000_0001);
        rd_chk(MRC_U64, 4, 64'h0123_4567_89AB_CDEF, 64'h0123_4567_89AB_CDEF);
        wr_chk(MRC_U16, 1, 64'h8000, 64'h8000);
        wr_chk(MRC_I16, 1, 64'h8000, 64'hFFFF_FFFF_FFFF_8000);
        wr_chk(MRC_I32, 2, 64'hFFFF_8000, 64'hFFFF_FFFF_FFFF_8000);
        wr_chk(MRC_U32, 2, 64'h89AB_CDEF, 64'h89AB_CDEF);
        wr_chk(MRC_U64, 4, 64'hFEDC_BA98_7654_3210, 64'hFEDC_BA98_7654_3210);
        $display("test integers finished");
    endtask : t_ints

    task automatic t_date();
        logic [63:0] ev;
        d_year  = 14'h7E8;
        d_month = 4'h2;
        d_day   = 5'h1B;
        ev = {32'(2024 * 10000 + 2 * 100 + 27), 32'h0};
        rd_chk(MRC_DATE, 4, 64'h0, ev);
        d_year  = 14'h7CA;
        d_month = 4'hA;
        d_day   = 5'hE;
        ev = {32'(1994 * 10000 + 10 * 100 + 14), 32'h0};
        rd_chk(MRC_DATE, 4, 64'h0, ev);
        wr_chk(MRC_DATE, 4, ev, ev);
        $display("test date finished");
    endtask : t_date

    task automatic t_real();
        rd_chk(MRC_REAL, 2, 64'hBFA0_0000, 64'hBFA0_0000);
        core_val = 64'h7FC0_0000;
        u_cli.read_value(MRC_REAL);
        chk_b({7'h0, u_cli.rx_exc}, 8'h01, "nan refused");
        chk_b(8'(u_cli.rx_n), 8'h00, "nan no words");
        chk_b(rd_exc_code, 8'h04, "read code");
        wr_chk(MRC_REAL, 2, 64'h42CF_4000, 64'h42CF_4000);
        $display("test real finished");
    endtask : t_real

    task automatic t_text();
        string       s;
        logic [7:0]  lo;
        logic [7:0]  hi;
        s = "Sun ok";
        for (int i = 0; i < 16; i++) begin
            lo = (2 * i < s.len()) ? s[2*i] : 8'h00;
            hi = (2 * i + 1 < s.len()) ? s[2*i+1] : 8'h00;
            u_cli.tx[i] = {hi, lo};
        end
        u_cli.send(MRC_TEXT, 16);
        wait_wr();
        chk_b({7'h0, wr_done}, 8'h01, "text done");
        chk_v(wr_res.val, 64'h0, "text value");
        // Busy stands through the whole field and drops with the last word
        fork
            u_cli.read_value(MRC_TEXT);
            begin
                @(posedge clk);
                #1;
                chk_b({7'h0, rd_busy}, 8'h01, "busy in read");
            end
        join
        chk_b({7'h0, rd_busy}, 8'h00, "busy after read");
        chk_b(8'(u_cli.rx_n), 8'h10, "text words");
        for (int i = 0; i < 16; i++) begin
            chk_w(u_cli.rx[i], u_cli.tx[i], "text word");
        end
        chr_chk(5'h00, 8'h53);
        chr_chk(5'h01, 8'h75);
        chr_chk(5'h05, 8'h6B);
        chr_chk(5'h1F, 8'h00);
        $display("test text finished");
    endtask : t_text

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        rst_b    = 1'b0;
        core_val = 64'h0;
        d_year   = 14'h0;
        d_month  = 4'h0;
        d_day    = 5'h0;
        chr_rd   = 1'b0;
        chr_idx  = 5'h00;
        repeat (2) @(posedge clk);
        #1;
        rst_b = 1'b1;
        @(posedge clk);
        #1;
        t_bool();
        t_ints();
        t_date();
        t_real();
        t_text();
        close_out();
    end
endmodule : test_modbus_register_value_codec
